// ### rtl/mrnalu_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the multiply-round/negate/normalize ALU
// Assumes: One core clock; 40-bit accumulators, 16-bit input registers
// Notes: Register map is word aligned on an 8-bit Wishbone byte address
//////////////////////////////////////////////////////////////////////////////
package mrnalu_pkg;

  localparam int ACC_W = 40;
  localparam int WORD_W = 16;
  localparam int INSN_W = 24;
  localparam int ACC_SIGN = 39;
  localparam int ACC_MID_MSB = 31;
  localparam int NORM_BIT = 30;
  localparam int SCALE_BIT = 29;
  localparam int MID_LSB = 16;

  // Condition code bit positions
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam int CC_U = 4;
  localparam int CC_E = 5;
  localparam int CC_L = 6;
  localparam int CC_S = 7;
  localparam logic [7:0] CCR_RESET = 8'h00;
  localparam logic [7:0] MASK_MULR = 8'h7C;
  localparam logic [7:0] MASK_NEG = 8'hFE;
  localparam logic [7:0] MASK_NORM = 8'h7A;

  // Opcode field positions and patterns
  localparam int F_SIGN = 2;
  localparam int F_DEST = 3;
  localparam int F_PAIR = 4;
  localparam int F_SRC2 = 4;
  localparam int F_SHIFT = 8;
  localparam int F_NSRC = 1;
  localparam int F_NDEST = 0;
  localparam logic [23:0] NOP_WORD = 24'h000000;
  localparam logic [15:0] IMM_PATTERN = 16'h0141;
  localparam logic [10:0] SHF_PATTERN = 11'h008;
  localparam logic [19:0] NORM_PATTERN = 20'h0C1E2;
  localparam logic [1:0] MUL_TAIL = 2'h1;
  localparam logic [1:0] IMM_MARK = 2'h3;
  localparam logic [3:0] NEG_HEAD = 4'h3;
  localparam logic [2:0] NEG_TAIL = 3'h6;
  localparam logic [2:0] NSRC_A = 3'h4;
  localparam logic [2:0] NSRC_B = 3'h5;

  // Input register indices and operand tables (element 0 on the right)
  localparam logic [1:0] IR_XL = 2'h0;
  localparam logic [1:0] IR_XU = 2'h1;
  localparam logic [1:0] IR_YL = 2'h2;
  localparam logic [1:0] IR_YU = 2'h3;
  localparam logic [7:0][1:0] PAIR_A = {IR_YU, IR_XU, IR_YL, IR_XL, IR_YU, IR_XU, IR_YL, IR_XL};
  localparam logic [7:0][1:0] PAIR_B = {IR_XU, IR_YL, IR_XL, IR_YU, IR_YL, IR_XL, IR_YL, IR_XL};
  localparam logic [3:0][1:0] SH_SRC = {IR_XU, IR_YL, IR_XL, IR_YU};
  localparam logic [3:0][1:0] IMM_SRC = {IR_YU, IR_XU, IR_YL, IR_XL};
  localparam logic [3:0][1:0] NORM_SRC = {IR_YU, IR_YL, IR_XU, IR_XL};

  localparam logic [39:0] ACC_ZERO = 40'h00_0000_0000;
  localparam logic [39:0] RND_HALF = 40'h00_0000_8000;
  localparam logic [15:0] RND_TIE = 16'h8000;
  localparam logic [39:0] ACC_MOST_NEG = 40'h80_0000_0000;
  localparam logic [5:0] SHIFT_CLAMP = 6'h28;

  // Wishbone register map
  localparam logic [7:0] OFF_IN0 = 8'h00;
  localparam logic [7:0] OFF_ACC0 = 8'h10;
  localparam logic [7:0] ACC_STRIDE = 8'h0C;
  localparam logic [7:0] OFF_CCR = 8'h28;
  localparam logic [7:0] OFF_CTRL = 8'h2C;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [1:0] PART_LOW = 2'h0;
  localparam logic [1:0] PART_MID = 2'h1;
  localparam logic [1:0] PART_EXT = 2'h2;
  localparam int CTRL_RND = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam int STAT_BUSY = 0;
  localparam logic [1:0] PC_STEP_ONE = 2'h1;
  localparam logic [1:0] PC_STEP_TWO = 2'h2;

  typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} mrnalu_state_e;

  typedef enum logic [2:0] {
    OP_NOP, OP_MULR_PAIR, OP_MULR_SHIFT, OP_MULR_IMM, OP_NEGATE, OP_FASTNORM, OP_ILLEGAL
  } mrnalu_op_e;

  typedef struct packed {
    logic [23:0] word;
    logic [15:0] ext;
  } mrnalu_issue_s;

  typedef struct packed {
    logic wr;
    logic dst;
    logic [39:0] res;
    logic ovf;
    logic [7:0] mask;
  } mrnalu_exec_s;

endpackage : mrnalu_pkg

// ### rtl/mrnalu_ccr_update.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Standard condition code computation from a 40-bit result
// Assumes: No scaling mode; limit is sticky
// Notes: Only bits set in mask_i change, the rest pass through
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module mrnalu_ccr_update import mrnalu_pkg::*; (
  input wire logic [39:0] result_i,
  input wire logic ovf_i,
  input wire logic [7:0] ccr_i,
  input wire logic [7:0] mask_i,
  output logic [7:0] ccr_o
);

  logic [7:0] std_flags;

  always_comb begin
    std_flags = ccr_i;
    std_flags[CC_S] = ccr_i[CC_S] | (result_i[NORM_BIT] ^ result_i[SCALE_BIT]);
    std_flags[CC_L] = ccr_i[CC_L] | ovf_i;
    std_flags[CC_E] = !((&result_i[ACC_SIGN:ACC_MID_MSB]) || !(|result_i[ACC_SIGN:ACC_MID_MSB]));
    std_flags[CC_U] = result_i[ACC_MID_MSB] == result_i[NORM_BIT];
    std_flags[CC_N] = result_i[ACC_SIGN];
    std_flags[CC_Z] = result_i == ACC_ZERO;
    std_flags[CC_V] = ovf_i;
    ccr_o = (std_flags & mask_i) | (ccr_i & ~mask_i);
  end

endmodule : mrnalu_ccr_update

// ### rtl/mrnalu_core.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Multiply-round, negate, no-op and fast normalize execution unit
// Assumes: Program control issues one decoded word plus its extension word
// Notes: One instruction in flight; Wishbone access stalls issue
//
// Summary of operation
// - Register multiply-round picks one of eight fixed register pairs by a 3-bit field.
// - One destination bit picks which accumulator receives a multiply-round result.
// - Sign bit set negates the product before rounding; clear leaves it.
// - Shift form scales one of four registers by two to the minus five-bit n.
// - Immediate form multiplies signed immediate by signed register into an accumulator.
// - Immediate multiplicand comes from the extension word after the opcode.
// - Immediate form picks its register operand from four by a 2-bit field.
// - Results round into the upper portion, convergent or two's-complement.
// - Low sixteen accumulator bits are cleared after rounding.
// - Immediate form updates flags six to two, keeps seven, one, zero.
// - Negate is zero minus accumulator, 40 bits, flags seven to one, carry kept.
// - All-zero word is no-op: program counter plus one, flags unchanged.
// - No-op lets pending work finish, then the next instruction follows.
// - Normalize: count bit 15 clear shifts right, else shifts left by minus count.
// - Normalize works on all forty bits, leading bit lands at bit 30.
// - Normalize sets overflow if bit 39 ever changes; flags six to three normal.
// - Normalize count comes from six sources; one bit picks the destination.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module mrnalu_core import mrnalu_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic issue_valid_i,
  input wire mrnalu_issue_s issue_i,
  output logic issue_ready_o,
  output logic done_o,
  output logic [1:0] pc_step_o,
  output logic illegal_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Helper functions

  function automatic logic [39:0] frac_mul(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    return {{7{p[31]}}, p, 1'b0};
  endfunction : frac_mul

  function automatic logic [39:0] place_mid(input logic [15:0] w);
    return {{8{w[15]}}, w, 16'h0000};
  endfunction : place_mid

  function automatic logic [39:0] round40(input logic [39:0] v, input logic conv);
    logic [39:0] r;
    r = v + RND_HALF;
    if (conv && v[15:0] == RND_TIE) begin
      r[MID_LSB] = 1'b0;
    end
    r[15:0] = 16'h0000;
    return r;
  endfunction : round40

  function automatic logic [15:0] lane16(input logic [15:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : lane16

  function automatic logic [7:0] acc_off(input logic i, input logic [1:0] part);
    return OFF_ACC0 + (i ? ACC_STRIDE : 8'h00) + {4'h0, part, 2'h0};
  endfunction : acc_off

  function automatic logic [7:0] in_off(input logic [1:0] idx);
    return OFF_IN0 + {4'h0, idx, 2'h0};
  endfunction : in_off

  function automatic mrnalu_op_e decode(input logic [23:0] w);
    if (w == NOP_WORD) begin
      return OP_NOP;
    end else if (w[23:4] == NORM_PATTERN) begin
      return (w[F_NSRC +: 3] > NSRC_B) ? OP_ILLEGAL : OP_FASTNORM;
    end else if (w[23:8] == IMM_PATTERN && w[7:6] == IMM_MARK && w[1:0] == MUL_TAIL) begin
      return OP_MULR_IMM;
    end else if (w[23:13] == SHF_PATTERN && w[7:6] == IMM_MARK && w[1:0] == MUL_TAIL) begin
      return OP_MULR_SHIFT;
    end else if (w[7] && w[1:0] == MUL_TAIL) begin
      return OP_MULR_PAIR;
    end else if (w[7:4] == NEG_HEAD && w[2:0] == NEG_TAIL) begin
      return OP_NEGATE;
    end else begin
      return OP_ILLEGAL;
    end
  endfunction : decode

  //////////////////////////////////////////////////////////////////////////////
  // State

  mrnalu_state_e state;
  mrnalu_op_e op_kind;
  logic [23:0] op_word;
  logic [15:0] op_ext;
  logic [15:0] in_reg [4];
  logic [39:0] acc [2];
  logic [7:0] ccr;
  logic round_mode;
  logic [7:0] next_ccr;
  logic [7:0] adr_w;
  logic wb_req;
  logic wb_wr;
  logic accept;
  logic exec;
  logic [39:0] prod;
  logic [39:0] signed_prod;
  logic [15:0] norm_cnt;
  logic [15:0] norm_amt;
  logic [5:0] norm_sh;
  logic [39:0] norm_res;
  logic norm_ovf;
  logic [31:0] rd_data;
  mrnalu_exec_s ex;

  assign adr_w = {wb_adr_i[7:2], 2'h0};
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr = wb_req && wb_we_i && wb_ack_o;
  assign exec = state == ST_EXEC;
  // Bus traffic blocks issue so a register write never meets an execute cycle
  assign issue_ready_o = (state == ST_IDLE) && !wb_req;
  assign accept = issue_valid_i && issue_ready_o;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer and decode capture

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (accept) state <= ST_EXEC;
        ST_EXEC: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_kind <= OP_NOP;
      op_word <= NOP_WORD;
      op_ext <= 16'h0000;
    end else if (accept) begin
      op_kind <= decode(issue_i.word);
      op_word <= issue_i.word;
      op_ext <= issue_i.ext;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      pc_step_o <= 2'h0;
      illegal_o <= 1'b0;
    end else begin
      done_o <= exec;
      pc_step_o <= !exec ? 2'h0 : (op_kind == OP_MULR_IMM) ? PC_STEP_TWO : PC_STEP_ONE;
      illegal_o <= exec && op_kind == OP_ILLEGAL;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Datapath

  always_comb begin
    case (op_kind)
      OP_MULR_PAIR: prod = frac_mul(in_reg[PAIR_A[op_word[F_PAIR +: 3]]],
                                    in_reg[PAIR_B[op_word[F_PAIR +: 3]]]);
      OP_MULR_SHIFT: prod = 40'($signed(place_mid(in_reg[SH_SRC[op_word[F_SRC2 +: 2]]]))
                                >>> op_word[F_SHIFT +: 5]);
      OP_MULR_IMM: prod = frac_mul(op_ext, in_reg[IMM_SRC[op_word[F_SRC2 +: 2]]]);
      default: prod = ACC_ZERO;
    endcase
    signed_prod = op_word[F_SIGN] ? ACC_ZERO - prod : prod;
  end

  always_comb begin
    if (op_word[F_NSRC +: 3] == NSRC_A) begin
      norm_cnt = acc[0][ACC_MID_MSB:MID_LSB];
    end else if (op_word[F_NSRC +: 3] == NSRC_B) begin
      norm_cnt = acc[1][ACC_MID_MSB:MID_LSB];
    end else begin
      norm_cnt = in_reg[NORM_SRC[op_word[F_NSRC +: 2]]];
    end
    norm_amt = norm_cnt[WORD_W-1] ? 16'h0000 - norm_cnt : norm_cnt;
    norm_sh = (norm_amt > {10'h000, SHIFT_CLAMP}) ? SHIFT_CLAMP : norm_amt[5:0];
    if (norm_cnt[WORD_W-1]) begin
      norm_res = acc[op_word[F_NDEST]] <<< norm_sh;
      norm_ovf = 40'($signed(norm_res) >>> norm_sh) != acc[op_word[F_NDEST]];
    end else begin
      norm_res = 40'($signed(acc[op_word[F_NDEST]]) >>> norm_sh);
      norm_ovf = 1'b0;
    end
  end

  always_comb begin
    ex = '0;
    ex.dst = op_word[F_DEST];
    case (op_kind)
      OP_MULR_PAIR, OP_MULR_SHIFT, OP_MULR_IMM: begin
        ex.wr = 1'b1;
        // Control bit clear selects convergent rounding
        ex.res = round40(signed_prod, !round_mode);
        ex.mask = MASK_MULR;
      end
      OP_NEGATE: begin
        ex.wr = 1'b1;
        ex.res = ACC_ZERO - acc[op_word[F_DEST]];
        ex.ovf = acc[op_word[F_DEST]] == ACC_MOST_NEG;
        ex.mask = MASK_NEG;
      end
      OP_FASTNORM: begin
        ex.wr = 1'b1;
        ex.dst = op_word[F_NDEST];
        ex.res = norm_res;
        ex.ovf = norm_ovf;
        ex.mask = MASK_NORM;
      end
      default: ex.wr = 1'b0;
    endcase
  end

  mrnalu_ccr_update u_ccr (
    .result_i(ex.res),
    .ovf_i(ex.ovf),
    .ccr_i(ccr),
    .mask_i(ex.mask),
    .ccr_o(next_ccr)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) in_reg[i] <= 16'h0000;
    end else if (wb_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (adr_w == in_off(2'(i))) in_reg[i] <= lane16(in_reg[i], wb_dat_i, wb_sel_i);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc[0] <= ACC_ZERO;
      acc[1] <= ACC_ZERO;
    end else if (exec && ex.wr) begin
      acc[ex.dst] <= ex.res;
    end else if (wb_wr) begin
      for (int i = 0; i < 2; i++) begin
        if (adr_w == acc_off(1'(i), PART_LOW)) begin
          acc[i][15:0] <= lane16(acc[i][15:0], wb_dat_i, wb_sel_i);
        end
        if (adr_w == acc_off(1'(i), PART_MID)) begin
          acc[i][ACC_MID_MSB:MID_LSB] <= lane16(acc[i][ACC_MID_MSB:MID_LSB], wb_dat_i, wb_sel_i);
        end
        if (adr_w == acc_off(1'(i), PART_EXT) && wb_sel_i[0]) begin
          acc[i][ACC_SIGN:ACC_MID_MSB+1] <= wb_dat_i[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ccr <= CCR_RESET;
    end else if (exec && ex.wr) begin
      ccr <= next_ccr;
    end else if (wb_wr && adr_w == OFF_CCR && wb_sel_i[0]) begin
      ccr <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      round_mode <= CTRL_RESET;
    end else if (wb_wr && adr_w == OFF_CTRL && wb_sel_i[0]) begin
      round_mode <= wb_dat_i[CTRL_RND];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  always_comb begin
    rd_data = 32'h0000_0000;
    if (adr_w == OFF_CCR) begin
      rd_data[7:0] = ccr;
    end else if (adr_w == OFF_CTRL) begin
      rd_data[CTRL_RND] = round_mode;
    end else if (adr_w == OFF_STATUS) begin
      rd_data[STAT_BUSY] = exec;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (adr_w == in_off(2'(i))) rd_data[15:0] = in_reg[i];
      end
      for (int i = 0; i < 2; i++) begin
        if (adr_w == acc_off(1'(i), PART_LOW)) rd_data[15:0] = acc[i][15:0];
        if (adr_w == acc_off(1'(i), PART_MID)) rd_data[15:0] = acc[i][ACC_MID_MSB:MID_LSB];
        if (adr_w == acc_off(1'(i), PART_EXT)) rd_data[7:0] = acc[i][ACC_SIGN:ACC_MID_MSB+1];
      end
    end
  end

  // Ack waits out an execute cycle; unmapped addresses still ack and read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o && !exec;
      if (wb_req && !wb_ack_o && !exec) wb_dat_o <= rd_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic cur_dst;
  logic norm_dst;
  assign cur_dst = op_word[F_DEST];
  assign norm_dst = op_word[F_NDEST];

  a_nop_flags_hold: assert property (
    exec && op_kind == OP_NOP |=> ccr == $past(ccr) && pc_step_o == PC_STEP_ONE && done_o)
    else $error("no-op changed flags or stepped wrongly");

  a_issue_done_time: assert property (
    accept |=> !issue_ready_o ##1 done_o)
    else $error("instruction did not finish two cycles after issue");

  a_neg_value_carry: assert property (
    exec && op_kind == OP_NEGATE
    |=> acc[cur_dst] == ACC_ZERO - $past(acc[cur_dst]) && ccr[CC_C] == $past(ccr[CC_C]))
    else $error("negate result or carry wrong");

  a_round_low_clear: assert property (
    exec && op_kind inside {OP_MULR_PAIR, OP_MULR_SHIFT, OP_MULR_IMM}
    |=> acc[cur_dst][15:0] == 16'h0000)
    else $error("low accumulator bits not cleared after rounding");

  a_other_acc_hold: assert property (
    exec && op_kind inside {OP_MULR_PAIR, OP_MULR_SHIFT, OP_MULR_IMM}
    |=> acc[!cur_dst] == $past(acc[!cur_dst]))
    else $error("multiply-round wrote the wrong accumulator");

  a_imm_flags_keep: assert property (
    exec && op_kind == OP_MULR_IMM
    |=> ccr[CC_S] == $past(ccr[CC_S]) && ccr[CC_V:CC_C] == $past(ccr[CC_V:CC_C])
        && pc_step_o == PC_STEP_TWO)
    else $error("immediate multiply-round touched protected flags");

  // Whole word compared, so the cleared low bits and the rounding mode are covered too
  a_imm_product: assert property (
    exec && op_kind == OP_MULR_IMM && !op_word[F_SIGN]
    |=> acc[cur_dst] ==
        $past(round40(frac_mul(op_ext, in_reg[IMM_SRC[op_word[F_SRC2 +: 2]]]), !round_mode)))
    else $error("immediate product mismatch");

  a_norm_right: assert property (
    exec && op_kind == OP_FASTNORM && !norm_cnt[WORD_W-1] && norm_cnt < 16'h0028
    |=> acc[norm_dst] == 40'($signed($past(acc[norm_dst])) >>> $past(norm_cnt))
        && !ccr[CC_V])
    else $error("normalize right shift or overflow flag wrong");

  a_norm_flags_keep: assert property (
    exec && op_kind == OP_FASTNORM
    |=> ccr[CC_Z] == $past(ccr[CC_Z]) && ccr[CC_C] == $past(ccr[CC_C])
        && ccr[CC_S] == $past(ccr[CC_S]))
    else $error("normalize changed unlisted flags");

  a_wb_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held longer than one cycle");

  c_negate_run: cover property (exec && op_kind == OP_NEGATE);
  c_norm_left: cover property (exec && op_kind == OP_FASTNORM && norm_cnt[WORD_W-1]);
  c_round_tie: cover property (exec && op_kind == OP_MULR_PAIR && signed_prod[15:0] == RND_TIE);
  c_bus_write: cover property (wb_wr);

endmodule : mrnalu_core

// ### verif/mrnalu_pcu_model.sv
// Purpose: Program control model offering decoded words to the ALU
// Assumes: One instruction in flight; waits for done before the next
// Notes: Idle issue lines show the inverse of the last word, never a held copy
`timescale 1ns/100ps
module mrnalu_pcu_model import mrnalu_pkg::*; (
  input wire logic clk_i,
  input wire logic issue_ready_i,
  input wire logic done_i,
  input wire logic [1:0] pc_step_i,
  input wire logic illegal_i,
  output logic issue_valid_o,
  output mrnalu_issue_s issue_o
);
  logic [15:0] pc = 16'h0000;
  initial begin
    issue_valid_o = 1'b0;
    issue_o = '0;
  end
  // Callers keep normalize counts within +8..-31
  task automatic run(input logic [23:0] w, input logic [15:0] x, output logic [1:0] st,
    output logic il);
    int i;
    st = 2'h3;
    il = 1'bx;
    @(posedge clk_i);
    issue_valid_o <= 1'b1;
    issue_o <= {w, x};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (issue_ready_i) break;
    end
    issue_valid_o <= 1'b0;
    issue_o <= ~{w, x};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (done_i) begin
        st = pc_step_i;
        il = illegal_i;
        pc <= pc + 16'(pc_step_i);
        break;
      end
    end
  endtask : run
endmodule : mrnalu_pcu_model

// ### verif/testbench.sv
// Purpose: Self-checking bench for the multiply-round/negate/normalize ALU
// Assumes: Partner model issues words; this bench is the Wishbone master
// Notes: Expected values worked by hand in fractional arithmetic
`timescale 1ns/100ps
module testbench import mrnalu_pkg::*; ;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wd = 32'h0;
  logic [3:0] wb_sel = 4'hF;
  logic [3:0] sel_use = 4'hF;
  logic [31:0] wb_rd, rdat;
  logic wb_ack, ready, valid, done, ill;
  logic [1:0] step;
  mrnalu_issue_s issue;
  int err_total = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  logic [15:0] pmid [8] = '{16'h0002, 16'h0012, 16'h0004, 16'h0018,
                            16'h0008, 16'h0006, 16'h000C, 16'h0010};
  initial forever #2 clk_i = ~clk_i;
  mrnalu_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd),
    .wb_ack_o(wb_ack), .issue_valid_i(valid), .issue_i(issue), .issue_ready_o(ready),
    .done_o(done), .pc_step_o(step), .illegal_o(ill));
  mrnalu_pcu_model pcu (.clk_i(clk_i), .issue_ready_i(ready), .done_i(done),
    .pc_step_i(step), .illegal_i(ill), .issue_valid_o(valid), .issue_o(issue));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wd <= d;
    wb_sel <= sel_use;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack === 1'b1) break;
    end
    rdat = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    // Idle address and data show the inverse so a late sample cannot pass by luck
    wb_adr <= ~a;
    wb_wd <= ~d;
    if (i == 20) chk("ack", 40'h1, 40'h0);
  endtask : wb
  task automatic set_acc(input logic d, input logic [39:0] v);
    logic [7:0] b;
    b = OFF_ACC0 + (d ? ACC_STRIDE : 8'h00);
    wb(1'b1, b, {16'h0, v[15:0]});
    wb(1'b1, b + 8'h04, {16'h0, v[31:16]});
    wb(1'b1, b + 8'h08, {24'h0, v[39:32]});
  endtask : set_acc
  task automatic acc_is(input logic d, input logic [39:0] e);
    logic [7:0] b;
    logic [39:0] v;
    b = OFF_ACC0 + (d ? ACC_STRIDE : 8'h00);
    wb(1'b0, b, 32'h0);
    v[15:0] = rdat[15:0];
    wb(1'b0, b + 8'h04, 32'h0);
    v[31:16] = rdat[15:0];
    wb(1'b0, b + 8'h08, 32'h0);
    v[39:32] = rdat[7:0];
    chk("acc", e, v);
  endtask : acc_is
  task automatic ccr_is(input logic [7:0] e);
    wb(1'b0, OFF_CCR, 32'h0);
    chk("ccr", 40'(e), 40'(rdat));
  endtask : ccr_is
  task automatic ex(input logic [23:0] w, input logic [15:0] x, input logic [1:0] es,
    input logic ei);
    logic [1:0] st;
    logic il;
    pcu.run(w, x, st, il);
    chk("pc_step", 40'(es), 40'(st));
    chk("illegal", 40'(ei), 40'(il));
  endtask : ex
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, well above the expected run length
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin : main
    logic [15:0] pc0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    ccr_is(CCR_RESET);
    wb(1'b1, 8'h3C, 32'hFFFF);
    wb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 40'h0, 40'(rdat));
    for (int i = 0; i < 4; i++) wb(1'b1, OFF_IN0 + 8'(4 * i), 32'(16'h0100 * (i + 1)));
    for (int q = 0; q < 8; q++) begin
      ex({16'h0, 1'b1, 3'(q), 1'(q), 3'b001}, 16'h0, PC_STEP_ONE, 1'b0);
      acc_is(1'(q), {8'h00, pmid[q], 16'h0});
    end
    $display("test pairs done");
    wb(1'b1, OFF_IN0, 32'h4000);
    wb(1'b1, OFF_CCR, 32'h81);
    ex(24'h0141C1, 16'h4000, PC_STEP_TWO, 1'b0);
    acc_is(1'b0, 40'h00_2000_0000);
    ccr_is(8'h91);
    ex(24'h0141CD, 16'h4000, PC_STEP_TWO, 1'b0);
    acc_is(1'b1, 40'hFF_E000_0000);
    ccr_is(8'h99);
    $display("test immediate done");
    wb(1'b1, OFF_IN0, 32'h0080);
    ex(24'h000081, 16'h0, PC_STEP_ONE, 1'b0);
    acc_is(1'b0, 40'h0);
    wb(1'b1, OFF_CTRL, 32'h1);
    ex(24'h000081, 16'h0, PC_STEP_ONE, 1'b0);
    acc_is(1'b0, 40'h00_0001_0000);
    ex(24'h0102C1, 16'h0, PC_STEP_ONE, 1'b0);
    acc_is(1'b0, 40'h00_0100_0000);
    $display("test rounding done");
    wb(1'b1, OFF_CCR, 32'h01);
    ex(24'h000036, 16'h0, PC_STEP_ONE, 1'b0);
    acc_is(1'b0, 40'hFF_FF00_0000);
    ccr_is(8'h19);
    set_acc(1'b0, ACC_MOST_NEG);
    wb(1'b1, OFF_CCR, 32'h0);
    ex(24'h000036, 16'h0, PC_STEP_ONE, 1'b0);
    acc_is(1'b0, ACC_MOST_NEG);
    ccr_is(8'h7A);
    pc0 = pcu.pc;
    ex(NOP_WORD, 16'h0, PC_STEP_ONE, 1'b0);
    ex(NOP_WORD, 16'h0, PC_STEP_ONE, 1'b0);
    ccr_is(8'h7A);
    chk("pc", 40'(pc0 + 16'h2), 40'(pcu.pc));
    $display("test negate nop done");
    set_acc(1'b0, 40'h20_0000_0000);
    set_acc(1'b1, 40'h00_0007_0000);
    wb(1'b1, OFF_CCR, 32'h85);
    ex(24'h0C1E2A, 16'h0, PC_STEP_ONE, 1'b0);
    acc_is(1'b0, 40'h00_4000_0000);
    ccr_is(8'h85);
    wb(1'b1, OFF_IN0, 32'hFFFD);
    set_acc(1'b1, 40'h00_0800_0000);
    ex(24'h0C1E21, 16'h0, PC_STEP_ONE, 1'b0);
    acc_is(1'b1, 40'h00_4000_0000);
    wb(1'b1, OFF_IN0, 32'hFFFF);
    set_acc(1'b0, 40'h40_0000_0000);
    wb(1'b1, OFF_CCR, 32'h0);
    ex(24'h0C1E20, 16'h0, PC_STEP_ONE, 1'b0);
    acc_is(1'b0, ACC_MOST_NEG);
    ccr_is(8'h7A);
    ex(24'h0C1E2C, 16'h0, PC_STEP_ONE, 1'b1);
    acc_is(1'b0, ACC_MOST_NEG);
    $display("test normalize done");
    sel_use = 4'h1;
    wb(1'b1, OFF_IN0, 32'h0000_AB12);
    sel_use = 4'hF;
    wb(1'b0, OFF_IN0, 32'h0);
    chk("lanes", 40'h00_0000_FF12, 40'(rdat));
    $display("test byte lanes done");
    finish_test();
  end
endmodule : testbench
